// *** hw/README_NONE.sv ***
`default_nettype none
`default_nettype wire

// *** hw/tmc_defines.svh ***
// register offsets, field positions, codes and reset values of the timer block
// assumes byte addresses on a 32-bit bus, one aligned word per register
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// global registers
`define TMC_OFS_RUN 8'h00
`define TMC_OFS_BUFCTL 8'h04
// channel windows
`define TMC_OFS_CHAN_A 8'h10
`define TMC_OFS_CHAN_B 8'h30
`define TMC_CHAN_SPAN 8'h1C
// offsets inside a channel window
`define TMC_OFS_MODE 8'h00
`define TMC_OFS_TOGGLE 8'h04
`define TMC_OFS_LOW 8'h08
`define TMC_OFS_PERIOD 8'h0C
`define TMC_OFS_CAPTURE_FIRST_A 8'h10
`define TMC_OFS_CAPTURE_SECOND_A 8'h14
`define TMC_OFS_COUNT 8'h18

// field positions
`define TMC_RUN_PRESC_BIT 7
`define TMC_MODE_SRC_LSB 0
`define TMC_MODE_CLE_BIT 2
`define TMC_MODE_CAPSEL_LSB 3
`define TMC_MODE_SWCAP_BIT 5
`define TMC_TOG_CMD_LSB 0
`define TMC_TOG_EN_LSB 2
`define TMC_TOG_AUXCMD_LSB 6
`define TMC_TOG_AUXEN_LSB 8

// codes
`define TMC_TFF_INV 2'b00
`define TMC_TFF_SET 2'b01
`define TMC_TFF_CLR 2'b10
`define TMC_TFF_HOLD 2'b11
`define TMC_SRC_EXT 2'b00
`define TMC_CAP_OFF 2'b00
`define TMC_CAP_RISE 2'b01
`define TMC_CAP_PULSE 2'b10
`define TMC_CAP_TFF 2'b11

// reset values
`define TMC_RST_SRC 2'b00
`define TMC_RST_CAPSEL 2'b00
`define TMC_RST_CLE 1'b0
`define TMC_RST_DBUF 2'b00
`define TMC_RST_WORD16 16'h0000
`define TMC_RST_TFF 1'b0

`endif

// *** hw/tmc_pkg.sv ***
// types shared by the timer top and its toggle flip-flops
// assumes tmc_defines.svh for all numeric values
`default_nettype none
package tmc_pkg;
    typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_RDWAIT = 1'b1} tmc_bus_st_t;
    typedef struct packed {
        logic [1:0] src;
        logic cle;
        logic [1:0] capsel;
        logic [3:0] ten;
        logic [1:0] auxen;
        logic [15:0] low;
        logic [15:0] lbuf;
        logic [15:0] period;
        logic [15:0] capture_first_a;
        logic [15:0] capture_second_a;
        logic [15:0] cnt;
    } tmc_chan_t;
    typedef struct packed {
        tmc_chan_t [1:0] ch;
        logic [1:0] run;
        logic presc_run;
        logic [1:0] dbuf;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] prev;
        tmc_bus_st_t bst;
        logic [7:0] addr;
        logic wr_pend;
        logic [31:0] rdata;
        logic ready;
        logic [1:0] ev_low;
        logic [1:0] ev_per;
        logic [1:0] ev_capture_first_a;
        logic [1:0] ev_capture_second_a;
        logic [1:0] ev_edge;
        logic [2:0] cmd_we;
        logic [2:0][1:0] cmd;
    } tmc_state_t;
    typedef struct packed {
        logic q;
    } tmc_tff_state_t;
endpackage
`default_nettype wire

// *** hw/tmc_tff.sv ***
// toggle flip-flop with four gated invert sources and a command port
// assumes source and command pulses are one cycle long, same clock
`include "tmc_defines.svh"
`default_nettype none
module tmc_tff (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // control and state
    tmc_tff_if.ff tff
);
    tmc_pkg::tmc_tff_state_t s_q;
    tmc_pkg::tmc_tff_state_t s_d;
    logic ev;

    always_comb begin
        s_d = s_q;
        ev = |(tff.src & tff.en);
        if (tff.cmd_we) begin
            unique case (tff.cmd)
                `TMC_TFF_INV: s_d.q = ~s_q.q ^ ev;
                `TMC_TFF_SET: s_d.q = 1'b1;
                `TMC_TFF_CLR: s_d.q = 1'b0;
                `TMC_TFF_HOLD: s_d.q = s_q.q ^ ev;
            endcase
        end else begin
            s_d.q = s_q.q ^ ev;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            s_q.q <= `TMC_RST_TFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign tff.q = s_q.q;
endmodule
`default_nettype wire

// *** hw/tmc_tff_if.sv ***
// carrier between the timer top and one toggle flip-flop
// assumes one clock; all members are driven on that clock
`default_nettype none
interface tmc_tff_if;
    logic [3:0] src;
    logic [3:0] en;
    logic cmd_we;
    logic [1:0] cmd;
    logic q;
    modport ctl (output src, output en, output cmd_we, output cmd, input q);
    modport ff (input src, input en, input cmd_we, input cmd, output q);
endinterface
`default_nettype wire

// *** hw/tmc_top.sv ***
// dual 16-bit timer/event counter with capture and compare, AHB-Lite slave
// assumes prescaler taps arrive as one-cycle pulses on clock_i; pins are async
`include "tmc_defines.svh"
`default_nettype none
module tmc_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // prescaler
    input wire logic [2:0] prescale_tick_i,
    output logic prescaler_run_o,
    // external pins
    input wire logic ext_input_a0_i,
    input wire logic ext_input_a1_i,
    input wire logic ext_input_b0_i,
    input wire logic ext_input_b1_i,
    input wire logic ext_tff_i,
    // toggle outputs
    output logic toggle_out_a_o,
    output logic toggle_out_aux_o,
    output logic toggle_out_b_o,
    // interrupt requests
    output logic low_match_irq_a_o,
    output logic period_match_irq_a_o,
    output logic low_match_irq_b_o,
    output logic period_match_irq_b_o,
    output logic ext_edge_irq_a_o,
    output logic ext_edge_irq_b_o
);
    tmc_pkg::tmc_state_t s_q;
    tmc_pkg::tmc_state_t s_d;

    tmc_tff_if tif_a ();
    tmc_tff_if tif_aux ();
    tmc_tff_if tif_b ();

    // channel window hit: {hit, relative offset}
    function automatic logic [8:0] chan_rel(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] r;
        r = a - base;
        chan_rel = {(a >= base) && (r <= `TMC_CHAN_SPAN), r};
    endfunction

    // internal count tick from the selected prescaler tap
    function automatic logic presc_pick(input logic [2:0] t, input logic [1:0] sel);
        logic p;
        p = 1'b0;
        unique case (sel)
            2'b01: p = t[0];
            2'b10: p = t[1];
            2'b11: p = t[2];
            2'b00: p = 1'b0;
        endcase
        presc_pick = p;
    endfunction

    function automatic logic [7:0] chan_base(input int i);
        chan_base = (i == 0) ? `TMC_OFS_CHAN_A : `TMC_OFS_CHAN_B;
    endfunction

    // register read view
    function automatic logic [31:0] reg_read(input tmc_pkg::tmc_state_t st, input logic [7:0] a);
        logic [31:0] v;
        logic [8:0] h;
        v = 32'h0000_0000;
        if (a == `TMC_OFS_RUN) begin
            v[1:0] = st.run;
            v[`TMC_RUN_PRESC_BIT] = st.presc_run;
        end
        if (a == `TMC_OFS_BUFCTL) begin
            v[1:0] = st.dbuf;
        end
        for (int i = 0; i < 2; i++) begin
            h = chan_rel(a, chan_base(i));
            if (h[8]) begin
                unique case (h[7:0])
                    `TMC_OFS_MODE: begin
                        v[`TMC_MODE_SRC_LSB +: 2] = st.ch[i].src;
                        v[`TMC_MODE_CLE_BIT] = st.ch[i].cle;
                        v[`TMC_MODE_CAPSEL_LSB +: 2] = st.ch[i].capsel;
                        v[`TMC_MODE_SWCAP_BIT] = 1'b1;
                    end
                    `TMC_OFS_TOGGLE: begin
                        v[`TMC_TOG_CMD_LSB +: 2] = `TMC_TFF_HOLD;
                        v[`TMC_TOG_EN_LSB +: 4] = st.ch[i].ten;
                        if (i == 0) begin
                            v[`TMC_TOG_AUXCMD_LSB +: 2] = `TMC_TFF_HOLD;
                            v[`TMC_TOG_AUXEN_LSB +: 2] = st.ch[i].auxen;
                        end
                    end
                    `TMC_OFS_LOW: v[15:0] = st.ch[i].low;
                    `TMC_OFS_PERIOD: v[15:0] = st.ch[i].period;
                    `TMC_OFS_CAPTURE_FIRST_A: v[15:0] = st.ch[i].capture_first_a;
                    `TMC_OFS_CAPTURE_SECOND_A: v[15:0] = st.ch[i].capture_second_a;
                    `TMC_OFS_COUNT: v[15:0] = st.ch[i].cnt;
                    default: v = 32'h0000_0000;
                endcase
            end
        end
        reg_read = v;
    endfunction

    always_comb begin
        logic [4:0] rise;
        logic [4:0] fall;
        logic tick;
        logic [15:0] cnt_n;
        logic [8:0] h;
        logic [31:0] w;
        logic capture_first_a_ev;
        logic capture_second_a_ev;
        logic [1:0] sel;
        rise = 5'h00;
        fall = 5'h00;
        tick = 1'b0;
        cnt_n = 16'h0000;
        h = 9'h000;
        w = hwdata_i;
        capture_first_a_ev = 1'b0;
        capture_second_a_ev = 1'b0;
        sel = 2'b00;
        s_d = s_q;

        // pin synchronisers and edge detect
        s_d.sync1 = {ext_tff_i, ext_input_b1_i, ext_input_b0_i, ext_input_a1_i, ext_input_a0_i};
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        rise = s_q.sync2 & ~s_q.prev;
        fall = ~s_q.sync2 & s_q.prev;

        // one-cycle pulses
        s_d.wr_pend = 1'b0;
        s_d.cmd_we = 3'b000;
        s_d.ev_low = 2'b00;
        s_d.ev_per = 2'b00;
        s_d.ev_capture_first_a = 2'b00;
        s_d.ev_capture_second_a = 2'b00;
        s_d.ev_edge = 2'b00;

        // bus address phase and read wait state
        if (s_q.bst == tmc_pkg::BUS_RDWAIT) begin
            s_d.rdata = reg_read(s_q, s_q.addr);
            s_d.ready = 1'b1;
            s_d.bst = tmc_pkg::BUS_IDLE;
        end else if (hsel_i && hready_i && htrans_i[1]) begin
            s_d.addr = haddr_i[7:0];
            if (hwrite_i) begin
                s_d.wr_pend = 1'b1;
            end else begin
                s_d.ready = 1'b0;
                s_d.bst = tmc_pkg::BUS_RDWAIT;
            end
        end

        // global register writes
        if (s_q.wr_pend && s_q.addr == `TMC_OFS_RUN) begin
            s_d.run = w[1:0];
            s_d.presc_run = w[`TMC_RUN_PRESC_BIT];
        end
        if (s_q.wr_pend && s_q.addr == `TMC_OFS_BUFCTL) begin
            s_d.dbuf = w[1:0];
        end

        // both channels share this code; nothing crosses between them
        for (int i = 0; i < 2; i++) begin
            sel = s_q.ch[i].capsel;
            if (s_q.ch[i].src == `TMC_SRC_EXT) begin
                tick = rise[2*i];
            end else begin
                tick = s_q.presc_run && presc_pick(prescale_tick_i, s_q.ch[i].src);
            end

            // counter: stopped means cleared
            if (!s_q.run[i]) begin
                cnt_n = 16'h0000;
                tick = 1'b0;
            end else if (tick && s_q.ch[i].cle && s_q.ch[i].cnt == s_q.ch[i].period) begin
                cnt_n = 16'h0000;
            end else if (tick) begin
                cnt_n = s_q.ch[i].cnt + 16'h0001;
            end else begin
                cnt_n = s_q.ch[i].cnt;
            end
            s_d.ch[i].cnt = cnt_n;

            // comparators
            s_d.ev_low[i] = tick && (cnt_n == s_q.ch[i].low);
            s_d.ev_per[i] = tick && (cnt_n == s_q.ch[i].period);
            if (s_d.ev_per[i] && s_q.dbuf[i]) begin
                s_d.ch[i].low = s_q.ch[i].lbuf;
            end

            // capture control
            capture_first_a_ev = ((sel == `TMC_CAP_RISE || sel == `TMC_CAP_PULSE) && rise[2*i])
                || (sel == `TMC_CAP_TFF && rise[4]);
            capture_second_a_ev = (sel == `TMC_CAP_RISE && rise[2*i+1])
                || (sel == `TMC_CAP_PULSE && fall[2*i])
                || (sel == `TMC_CAP_TFF && fall[4]);
            s_d.ev_edge[i] = (sel == `TMC_CAP_PULSE) ? fall[2*i] : rise[2*i];

            // channel register writes
            h = chan_rel(s_q.addr, chan_base(i));
            if (s_q.wr_pend && h[8]) begin
                unique case (h[7:0])
                    `TMC_OFS_MODE: begin
                        s_d.ch[i].src = w[`TMC_MODE_SRC_LSB +: 2];
                        s_d.ch[i].cle = w[`TMC_MODE_CLE_BIT];
                        s_d.ch[i].capsel = w[`TMC_MODE_CAPSEL_LSB +: 2];
                        if (!w[`TMC_MODE_SWCAP_BIT] && s_q.presc_run) begin
                            capture_first_a_ev = 1'b1;
                        end
                    end
                    `TMC_OFS_TOGGLE: begin
                        s_d.ch[i].ten = w[`TMC_TOG_EN_LSB +: 4];
                        s_d.cmd_we[2*i] = 1'b1;
                        s_d.cmd[2*i] = w[`TMC_TOG_CMD_LSB +: 2];
                        if (i == 0) begin
                            s_d.ch[i].auxen = w[`TMC_TOG_AUXEN_LSB +: 2];
                            s_d.cmd_we[1] = 1'b1;
                            s_d.cmd[1] = w[`TMC_TOG_AUXCMD_LSB +: 2];
                        end
                    end
                    `TMC_OFS_LOW: begin
                        s_d.ch[i].lbuf = w[15:0];
                        if (!s_q.dbuf[i]) begin
                            s_d.ch[i].low = w[15:0];
                        end
                    end
                    `TMC_OFS_PERIOD: s_d.ch[i].period = w[15:0];
                    default: s_d.ch[i].period = s_d.ch[i].period;
                endcase
            end

            // capture latches take the counter before this tick
            if (capture_first_a_ev) begin
                s_d.ch[i].capture_first_a = s_q.ch[i].cnt;
            end
            if (capture_second_a_ev) begin
                s_d.ch[i].capture_second_a = s_q.ch[i].cnt;
            end
            s_d.ev_capture_first_a[i] = capture_first_a_ev;
            s_d.ev_capture_second_a[i] = capture_second_a_ev;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 2; i++) begin
                s_q.ch[i].src <= `TMC_RST_SRC;
                s_q.ch[i].cle <= `TMC_RST_CLE;
                s_q.ch[i].capsel <= `TMC_RST_CAPSEL;
                s_q.ch[i].ten <= 4'h0;
                s_q.ch[i].auxen <= 2'h0;
                s_q.ch[i].low <= `TMC_RST_WORD16;
                s_q.ch[i].lbuf <= `TMC_RST_WORD16;
                s_q.ch[i].period <= `TMC_RST_WORD16;
                s_q.ch[i].capture_first_a <= `TMC_RST_WORD16;
                s_q.ch[i].capture_second_a <= `TMC_RST_WORD16;
                s_q.ch[i].cnt <= `TMC_RST_WORD16;
            end
            s_q.run <= 2'b00;
            s_q.presc_run <= 1'b0;
            s_q.dbuf <= `TMC_RST_DBUF;
            s_q.sync1 <= 5'h00;
            s_q.sync2 <= 5'h00;
            s_q.prev <= 5'h00;
            s_q.bst <= tmc_pkg::BUS_IDLE;
            s_q.addr <= 8'h00;
            s_q.wr_pend <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.ready <= 1'b1;
            s_q.ev_low <= 2'b00;
            s_q.ev_per <= 2'b00;
            s_q.ev_capture_first_a <= 2'b00;
            s_q.ev_capture_second_a <= 2'b00;
            s_q.ev_edge <= 2'b00;
            s_q.cmd_we <= 3'b000;
            s_q.cmd <= {3{`TMC_TFF_HOLD}};
        end else begin
            s_q <= s_d;
        end
    end

    // toggle flip-flop wiring
    assign tif_a.src = {s_q.ev_capture_second_a[0], s_q.ev_capture_first_a[0], s_q.ev_per[0], s_q.ev_low[0]};
    assign tif_a.en = s_q.ch[0].ten;
    assign tif_a.cmd_we = s_q.cmd_we[0];
    assign tif_a.cmd = s_q.cmd[0];
    assign tif_aux.src = {2'b00, s_q.ev_capture_second_a[0], s_q.ev_per[0]};
    assign tif_aux.en = {2'b00, s_q.ch[0].auxen};
    assign tif_aux.cmd_we = s_q.cmd_we[1];
    assign tif_aux.cmd = s_q.cmd[1];
    assign tif_b.src = {s_q.ev_capture_second_a[1], s_q.ev_capture_first_a[1], s_q.ev_per[1], s_q.ev_low[1]};
    assign tif_b.en = s_q.ch[1].ten;
    assign tif_b.cmd_we = s_q.cmd_we[2];
    assign tif_b.cmd = s_q.cmd[2];

    tmc_tff u_tff_a (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .tff(tif_a.ff)
    );
    tmc_tff u_tff_aux (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .tff(tif_aux.ff)
    );
    tmc_tff u_tff_b (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .tff(tif_b.ff)
    );

    // outputs
    assign hrdata_o = s_q.rdata;
    assign hreadyout_o = s_q.ready;
    assign hresp_o = 1'b0;
    assign prescaler_run_o = s_q.presc_run;
    assign toggle_out_a_o = tif_a.q;
    assign toggle_out_aux_o = tif_aux.q;
    assign toggle_out_b_o = tif_b.q;
    assign low_match_irq_a_o = s_q.ev_low[0];
    assign period_match_irq_a_o = s_q.ev_per[0];
    assign low_match_irq_b_o = s_q.ev_low[1];
    assign period_match_irq_b_o = s_q.ev_per[1];
    assign ext_edge_irq_a_o = s_q.ev_edge[0];
    assign ext_edge_irq_b_o = s_q.ev_edge[1];
endmodule
`default_nettype wire

// *** tb/tmc_pins_model.sv ***
// far side of the timer: prescaler taps and external pulse sources
// assumes pins idle low; taps only while the prescaler run output is high
`default_nettype none
module tmc_pins_model (
    // clock
    input wire logic clock_i,
    // prescaler
    input wire logic prescaler_run_i,
    output logic [2:0] prescale_tick_o,
    // external pins a0, a1, b0, b1, flip-flop
    output logic [4:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div = 3'h0;
    initial begin
        prescale_tick_o = 3'h0;
        pins_o = 5'h00;
    end
    // taps at 1/2, 1/4, 1/8 of the clock
    always @(posedge clock_i) begin
        div <= div + 3'h1;
        prescale_tick_o <= prescaler_run_i ? {div == 3'h7, div[1:0] == 2'h3, div[0]} : 3'h0;
    end
    // one clean rising edge, then back low
    task pulse(input int idx);
        pins_o[idx] <= 1'b1;
        repeat (8) @(posedge clock_i);
        pins_o[idx] <= 1'b0;
        repeat (8) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// *** tb/tmc_top_bench.sv ***
// self-checking bench for the timer top
// assumes the pins model for taps and pulses; hready is hreadyout_o
`include "tmc_defines.svh"
`default_nettype none
module tmc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ca = `TMC_OFS_CHAN_A;
    localparam logic [7:0] cb = `TMC_OFS_CHAN_B;
    localparam logic [7:0] o_tog = `TMC_OFS_TOGGLE;
    localparam logic [7:0] o_low = `TMC_OFS_LOW;
    localparam logic [7:0] o_per = `TMC_OFS_PERIOD;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } tmc_row_t;
    tmc_row_t rows [8] = '{'{ca + o_per, 32'hABCD1234, 32'h00001234},
        '{ca + o_low, 32'h00000055, 32'h00000055}, '{cb + o_per, 32'h0000BEEF, 32'h0000BEEF},
        '{cb + o_low, 32'hFFFF0001, 32'h00000001}, '{ca + o_tog, 32'h0000003F, 32'h000000FF},
        '{cb + o_tog, 32'h0000003F, 32'h0000003F}, '{8'h80, 32'hFFFFFFFF, 32'h00000000},
        '{ca + `TMC_OFS_COUNT, 32'h00001234, 32'h00000000}};
    logic [1:0] cmds [5] = '{`TMC_TFF_CLR, `TMC_TFF_SET, `TMC_TFF_INV, `TMC_TFF_INV, `TMC_TFF_HOLD};
    logic [4:0] exps = 5'b11010;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, rd, v;
    logic hreadyout_o, hresp_o, prescaler_run_o, toggle_out_a_o, toggle_out_aux_o;
    logic toggle_out_b_o, lia, pia, lib, pib, eia, eib, toa_q = 1'b0, t, ta, lvl_l, lvl_p;
    logic [2:0] prescale_tick_i;
    logic [4:0] pins;
    logic [1:0] ld = 2'h0, pd = 2'h0;
    int n_errors = 0, compares = 0, cyc = 0, n_tog = 0, n_per = 0, n_edge = 0, s, s2;
    int t_per = 0, t_low = 0, gap_p = 0, d_lp = 0, n_pb = 0, n_eb = 0;
    tmc_top tmc_top_inst (.clock_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .prescale_tick_i,
        .prescaler_run_o, .ext_input_a0_i(pins[0]), .ext_input_a1_i(pins[1]),
        .ext_input_b0_i(pins[2]), .ext_input_b1_i(pins[3]), .ext_tff_i(pins[4]),
        .toggle_out_a_o, .toggle_out_aux_o, .toggle_out_b_o, .low_match_irq_a_o(lia),
        .period_match_irq_a_o(pia), .low_match_irq_b_o(lib), .period_match_irq_b_o(pib),
        .ext_edge_irq_a_o(eia), .ext_edge_irq_b_o(eib));
    tmc_pins_model tmc_pins_model_inst (.clock_i, .prescaler_run_i(prescaler_run_o),
        .prescale_tick_o(prescale_tick_i), .pins_o(pins));
    initial forever #10 clock_i = ~clock_i;
    // event timestamps and flip-flop levels after each match
    always @(posedge clock_i) begin
        cyc++;
        toa_q <= toggle_out_a_o;
        ld <= {ld[0], lia};
        pd <= {pd[0], pia};
        if (toggle_out_a_o !== toa_q) n_tog++;
        if (eia === 1'b1) n_edge++;
        if (eib === 1'b1) n_eb++;
        if (pib === 1'b1) n_pb++;
        if (lia === 1'b1) t_low <= cyc;
        if (ld[1]) lvl_l <= toggle_out_a_o;
        if (pd[1]) lvl_p <= toggle_out_a_o;
        if (pia === 1'b1) begin
            n_per++;
            gap_p <= cyc - t_per;
            t_per <= cyc;
            d_lp <= cyc - t_low;
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge clock_i);
            i++;
        end while (hreadyout_o !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_errors++;
            end_sim();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= 2'h2;
        wait_rdy();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_rdy();
        rd = hrdata_o;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        bus(0, ca, 0);
        check("mode reset", rd, 32'h00000020);
        $display("reset test done");
        foreach (rows[i]) begin
            bus(1, rows[i].a, rows[i].w);
            bus(0, rows[i].a, 0);
            check("register", rd, rows[i].e);
        end
        $display("register table done");
        bus(1, ca + o_per, 4);
        bus(1, ca + o_low, 2);
        bus(1, ca + o_tog, 32'h0E);
        bus(1, ca, 32'h25);
        bus(1, 0, 32'h81);
        repeat (60) @(posedge clock_i);
        check("period gap", gap_p, 10);
        check("low to period", d_lp, 4);
        check("pulse levels", lvl_l ^ lvl_p, 1);
        bus(1, ca + o_tog, 32'h03);
        s = n_tog;
        s2 = n_per;
        repeat (40) @(posedge clock_i);
        check("gated toggle", n_tog - s, 0);
        check("period irqs", n_per - s2 > 3, 1);
        $display("interval test done");
        bus(1, 0, 32'h80);
        bus(1, 4, 1);
        bus(1, ca + o_low, 3);
        bus(0, ca + o_low, 0);
        check("low buffered", rd, 2);
        bus(1, 0, 32'h81);
        repeat (30) @(posedge clock_i);
        bus(0, ca + o_low, 0);
        check("low loaded", rd, 3);
        $display("buffer test done");
        for (int i = 0; i < 5; i++) begin
            bus(1, ca + o_tog, {24'h0, cmds[i], 4'h0, cmds[i]});
            bus(1, cb + o_tog, {30'h0, cmds[i]});
            repeat (3) @(posedge clock_i);
            check("flip-flop a", toggle_out_a_o, exps[i]);
            check("flip-flop aux", toggle_out_aux_o, exps[i]);
            check("flip-flop b", toggle_out_b_o, exps[i]);
        end
        $display("command test done");
        bus(1, ca, 32'h21);
        bus(1, 0, 32'h80);
        s = n_per;
        bus(1, 0, 32'h81);
        repeat (40) @(posedge clock_i);
        bus(1, ca, 32'h01);
        bus(0, ca + `TMC_OFS_CAPTURE_FIRST_A, 0);
        v = rd;
        bus(0, ca + `TMC_OFS_COUNT, 0);
        check("free run", v > 32'h4, 1);
        check("single match", n_per - s, 1);
        check("soft capture", v < rd, 1);
        $display("free run test done");
        bus(1, cb, 32'h20);
        bus(1, cb + o_per, 5);
        bus(1, 0, 32'h82);
        s = n_eb;
        s2 = n_pb;
        for (int i = 0; i < 5; i++) tmc_pins_model_inst.pulse(2);
        bus(1, cb, 32'h00);
        bus(0, cb + `TMC_OFS_CAPTURE_FIRST_A, 0);
        check("event count", rd, 5);
        check("edge irqs b", n_eb - s, 5);
        check("period irq b", n_pb - s2, 1);
        $display("event test done");
        bus(1, ca, 32'h29);
        bus(1, ca + o_tog, 32'h2D3);
        bus(1, 0, 32'h83);
        s = n_edge;
        t = !toggle_out_a_o;
        ta = !toggle_out_aux_o;
        tmc_pins_model_inst.pulse(0);
        bus(0, ca + `TMC_OFS_CAPTURE_FIRST_A, 0);
        v = rd;
        check("edge irq", n_edge - s, 1);
        check("capture toggle", toggle_out_a_o, t);
        tmc_pins_model_inst.pulse(1);
        bus(0, ca + `TMC_OFS_CAPTURE_SECOND_A, 0);
        check("capture order", rd > v, 1);
        check("aux capture", toggle_out_aux_o, ta);
        check("main held", toggle_out_a_o, t);
        $display("capture test done");
        v = rd;
        bus(1, 4, 0);
        bus(1, ca + o_tog, 32'hCE);
        bus(1, ca + o_low, v + 32);
        bus(1, ca + o_per, v + 48);
        s = n_tog;
        repeat (90) @(posedge clock_i);
        bus(1, ca + o_tog, 32'hC3);
        check("one-shot edges", n_tog - s, 2);
        check("one-shot width", d_lp, 32);
        $display("one-shot test done");
        end_sim();
    end
endmodule
`default_nettype wire

// *** tb/tmc_top_monitor.sv ***
// port checker for the timer top
// assumes bus hready is the slave's own hreadyout
`default_nettype none
module tmc_top_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // bus
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // pins and requests
    input wire logic prescaler_run_o,
    input wire logic ext_input_a0_i,
    input wire logic toggle_out_a_o,
    input wire logic toggle_out_aux_o,
    input wire logic toggle_out_b_o,
    input wire logic period_match_irq_a_o,
    input wire logic low_match_irq_b_o,
    input wire logic ext_edge_irq_a_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic req;
    assign req = hsel_i & hready_i & htrans_i[1];
    chk_resp_okay: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (req && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (req && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    chk_rdata_hold: assert property ($past(rst_b_i) && hreadyout_o && $past(hreadyout_o)
        |-> $stable(hrdata_o))
        else $error("read data moved");
    chk_reset_quiet: assert property ($rose(rst_b_i) |-> !toggle_out_a_o
        && !toggle_out_aux_o && !toggle_out_b_o && !prescaler_run_o && hreadyout_o)
        else $error("outputs not at reset level");
    chk_period_pulse_a: assert property (period_match_irq_a_o |=> !period_match_irq_a_o)
        else $error("period request too long");
    chk_low_pulse_b: assert property (low_match_irq_b_o |=> !low_match_irq_b_o)
        else $error("low request too long");
    chk_edge_irq_pin: assert property (ext_edge_irq_a_o |-> $past(ext_input_a0_i, 3))
        else $error("edge request without pin rise");
    cover property (period_match_irq_a_o);
    cover property ($rose(toggle_out_aux_o));
    cover property (ext_edge_irq_a_o);
endmodule
bind tmc_top tmc_top_monitor tmc_top_monitor_inst (.clock_i, .rst_b_i, .hsel_i, .htrans_i,
    .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .prescaler_run_o, .ext_input_a0_i,
    .toggle_out_a_o, .toggle_out_aux_o, .toggle_out_b_o, .period_match_irq_a_o,
    .low_match_irq_b_o, .ext_edge_irq_a_o);
`default_nettype wire
